// [hdl/ipma_pkg.sv]
// Shared constants for the paged two-wire memory slave
package ipma_pkg;
  localparam logic [3:0] SLAVE_ADDR_HI = 4'hA;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ROW_BITS = 3;
  localparam logic [7:0] EE_USER_LAST = 8'h3F;
  localparam logic [7:0] RSVD_FIRST = 8'h40;
  localparam logic [7:0] RSVD_LAST = 8'hE7;
  localparam logic [7:0] SHADOW_FIRST = 8'hF0;
  localparam logic [7:0] SHADOW_LAST = 8'hF7;
  localparam logic [7:0] CFG_ADDR = 8'hF4;
  localparam int SHADOW_ONLY_BIT = 0;
  localparam logic [7:0] STAT0_ADDR = 8'hF8;
  localparam logic [7:0] STAT1_ADDR = 8'hF9;
  localparam logic [7:0] IOCTL0_ADDR = 8'hF2;
  localparam logic [7:0] IOCTL1_ADDR = 8'hF3;
  localparam logic [7:0] IOCTL0_RST = 8'hFF;
  localparam logic [7:0] IOCTL1_RST = 8'h01;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam int SYS_CLK_MHZ = 125;
  localparam int NV_PROGRAM_TIME_US = 10;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] K_SADDR = 2'h0;
  localparam logic [1:0] K_MADDR = 2'h1;
  localparam logic [1:0] K_DATA = 2'h2;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RX = 6'h02,
    S_STALL = 6'h04,
    S_ACK = 6'h08,
    S_TX = 6'h10,
    S_RACK = 6'h20
  } ipma_state_t;
endpackage

// [hdl/ipma_buf.sv]
// Small valid/ready buffer of flip-flops
`timescale 1ns/100ps
`default_nettype none
module ipma_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } ipma_buf_t;
  ipma_buf_t cur, next_cur;
  logic push, pop;

  assign in_ready = (cur.cnt != FULL);
  assign out_valid = (cur.cnt != '0);
  assign out_data = cur.slot[cur.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.slot[cur.wp] = in_data;
      next_cur.wp = (cur.wp == PW'(DEPTH - 1)) ? '0 : cur.wp + PW'(1);
    end
    if (pop) begin
      next_cur.rp = (cur.rp == PW'(DEPTH - 1)) ? '0 : cur.rp + PW'(1);
    end
    next_cur.cnt = cur.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rstn) cur.cnt <= FULL)
    else $error("buffer count above depth");
endmodule
`default_nettype wire

// [hdl/ipma_top.sv]
// Two-wire slave with paged memory and program-time tracking
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Foreign slave address: idle until next start
// - Second write byte loads the address counter
// - Counter advances after every received data byte
// - Write counter wraps inside its 8-byte row
// - No address acknowledge while page programs
// - Whole page programmed, untouched bytes kept
// - Reads start at current counter value
// - Dummy write then repeated start sets read
// - Master ack requests more bytes, nack ends
// - Upper seven bits match, straps low three
// - Ninth bit low acknowledges, high refuses
// - Shadow-only bit skips programming shadowed bytes
module ipma_top #(
  parameter int NV_PROGRAM_TIME_US = ipma_pkg::NV_PROGRAM_TIME_US
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  output logic nv_busy
);
  localparam int NV_CYC = NV_PROGRAM_TIME_US * ipma_pkg::SYS_CLK_MHZ;
  localparam int CW = $clog2(NV_CYC + 1);

  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic [2:0] strap_m, strap_s;
    logic busy_m, busy_s;
    ipma_pkg::ipma_state_t st;
    logic [1:0] kind;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] addr;
    logic to_tx;
    logic nack;
    logic page_dirty;
    logic commit_tgl;
    logic pend;
    logic seen_busy;
    logic sda_oe, scl_oe, drv_zero;
    logic [255:0][7:0] mem;
  } ipma_link_t;

  typedef struct packed {
    logic tgl_m, tgl_s, tgl_p;
    logic [CW-1:0] cnt;
    logic busy;
  } ipma_sys_t;

  ipma_link_t lk, next_lk;
  ipma_sys_t sy, next_sy;
  logic ev_rise, ev_fall, ev_start, ev_stop, match, load_now, shadow_only;
  logic push_valid, push_ready, drain_valid, drain_ready, drain_dirty;
  logic [15:0] drain_word;
  logic [7:0] rd_byte, rd_addr, daddr;

  assign scl_out = lk.drv_zero;
  assign sda_out = lk.drv_zero;
  assign scl_oe = lk.scl_oe;
  assign sda_oe = lk.sda_oe;
  assign nv_busy = sy.busy;

  assign ev_rise = lk.scl_s && !lk.scl_p;
  assign ev_fall = !lk.scl_s && lk.scl_p;
  assign ev_start = lk.scl_s && lk.scl_p && lk.sda_p && !lk.sda_s;
  assign ev_stop = lk.scl_s && lk.scl_p && !lk.sda_p && lk.sda_s;
  assign match = (lk.shreg[7:1] == {ipma_pkg::SLAVE_ADDR_HI, lk.strap_s}) && !lk.pend;
  assign shadow_only = lk.mem[ipma_pkg::CFG_ADDR][ipma_pkg::SHADOW_ONLY_BIT];
  assign load_now = ev_fall && !ev_start && !ev_stop
    && ((lk.st == ipma_pkg::S_ACK && lk.to_tx) || (lk.st == ipma_pkg::S_RACK && !lk.nack));
  assign rd_addr = lk.addr;
  assign rd_byte = ((rd_addr >= ipma_pkg::RSVD_FIRST && rd_addr <= ipma_pkg::RSVD_LAST)
    || rd_addr == ipma_pkg::STAT0_ADDR || rd_addr == ipma_pkg::STAT1_ADDR) ? 8'h00 : lk.mem[rd_addr];
  assign push_valid = (lk.st == ipma_pkg::S_STALL) && !ev_start && !ev_stop;
  assign drain_ready = !lk.busy_s && !load_now;
  assign daddr = drain_word[15:8];
  assign drain_dirty = drain_valid && drain_ready
    && (daddr <= ipma_pkg::EE_USER_LAST || (daddr > ipma_pkg::RSVD_LAST && daddr <= ipma_pkg::SHADOW_LAST))
    && !(shadow_only && daddr >= ipma_pkg::SHADOW_FIRST);

  ipma_buf #(
    .WIDTH(16),
    .DEPTH(ipma_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(link_clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({lk.addr, lk.shreg}),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_word)
  );

  // Link side protocol engine
  always_comb begin
    next_lk = lk;
    next_lk.scl_m = scl_in;
    next_lk.scl_s = lk.scl_m;
    next_lk.scl_p = lk.scl_s;
    next_lk.sda_m = sda_in;
    next_lk.sda_s = lk.sda_m;
    next_lk.sda_p = lk.sda_s;
    next_lk.strap_m = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    next_lk.strap_s = lk.strap_m;
    next_lk.busy_m = sy.busy;
    next_lk.busy_s = lk.busy_m;
    // Busy handshake from the program timer
    if (lk.pend && lk.busy_s) begin
      next_lk.seen_busy = 1'b1;
    end
    if (lk.pend && lk.seen_busy && !lk.busy_s) begin
      next_lk.pend = 1'b0;
      next_lk.seen_busy = 1'b0;
    end
    // Drain: only the addressed byte changes, rest of page kept
    if (drain_valid && drain_ready) begin
      if (!((daddr >= ipma_pkg::RSVD_FIRST && daddr <= ipma_pkg::RSVD_LAST)
          || daddr == ipma_pkg::STAT0_ADDR || daddr == ipma_pkg::STAT1_ADDR)) begin
        next_lk.mem[daddr] = drain_word[7:0];
      end
      if (drain_dirty) begin
        next_lk.page_dirty = 1'b1;
      end
    end
    case (lk.st)
      ipma_pkg::S_IDLE: begin
        next_lk.sda_oe = 1'b0;
      end
      ipma_pkg::S_RX: begin
        if (ev_rise) begin
          next_lk.shreg = {lk.shreg[6:0], lk.sda_s};
          next_lk.bitcnt = lk.bitcnt + 4'h1;
        end else if (ev_fall && lk.bitcnt == 4'h8) begin
          next_lk.bitcnt = 4'h0;
          case (lk.kind)
            ipma_pkg::K_SADDR: begin
              if (match) begin
                next_lk.st = ipma_pkg::S_ACK;
                next_lk.sda_oe = 1'b1;
                next_lk.to_tx = lk.shreg[0];
                next_lk.kind = ipma_pkg::K_MADDR;
              end else begin
                next_lk.st = ipma_pkg::S_IDLE;
              end
            end
            ipma_pkg::K_MADDR: begin
              next_lk.addr = lk.shreg;
              next_lk.st = ipma_pkg::S_ACK;
              next_lk.sda_oe = 1'b1;
              next_lk.kind = ipma_pkg::K_DATA;
            end
            default: begin
              next_lk.st = ipma_pkg::S_STALL;
              next_lk.scl_oe = 1'b1;
            end
          endcase
        end
      end
      ipma_pkg::S_STALL: begin
        // Hold the clock low until the buffer takes the byte
        if (push_ready) begin
          next_lk.addr = {lk.addr[7:ipma_pkg::ROW_BITS], lk.addr[2:0] + 3'h1};
          next_lk.scl_oe = 1'b0;
          next_lk.sda_oe = 1'b1;
          next_lk.st = ipma_pkg::S_ACK;
        end
      end
      ipma_pkg::S_ACK: begin
        if (ev_fall) begin
          next_lk.sda_oe = 1'b0;
          next_lk.st = ipma_pkg::S_RX;
        end
      end
      ipma_pkg::S_TX: begin
        if (ev_fall) begin
          next_lk.bitcnt = lk.bitcnt + 4'h1;
          if (lk.bitcnt == 4'h7) begin
            next_lk.sda_oe = 1'b0;
            next_lk.st = ipma_pkg::S_RACK;
          end else begin
            next_lk.shreg = {lk.shreg[6:0], 1'b0};
            next_lk.sda_oe = !lk.shreg[6];
          end
        end
      end
      ipma_pkg::S_RACK: begin
        if (ev_rise) begin
          next_lk.nack = lk.sda_s;
        end else if (ev_fall && lk.nack) begin
          next_lk.st = ipma_pkg::S_IDLE;
        end
      end
      default: begin
        next_lk.st = ipma_pkg::S_IDLE;
      end
    endcase
    if (load_now) begin
      next_lk.shreg = rd_byte;
      next_lk.addr = lk.addr + 8'h01;
      next_lk.sda_oe = !rd_byte[7];
      next_lk.bitcnt = 4'h0;
      next_lk.nack = 1'b0;
      next_lk.st = ipma_pkg::S_TX;
    end
    if (ev_start) begin
      next_lk.st = ipma_pkg::S_RX;
      next_lk.kind = ipma_pkg::K_SADDR;
      next_lk.bitcnt = 4'h0;
      next_lk.sda_oe = 1'b0;
      next_lk.scl_oe = 1'b0;
    end
    if (ev_stop) begin
      next_lk.st = ipma_pkg::S_IDLE;
      next_lk.sda_oe = 1'b0;
      next_lk.scl_oe = 1'b0;
      if (lk.page_dirty || drain_dirty) begin
        next_lk.commit_tgl = !lk.commit_tgl;
        next_lk.pend = 1'b1;
        next_lk.seen_busy = 1'b0;
        next_lk.page_dirty = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lk <= '0;
      lk.scl_m <= 1'b1;
      lk.scl_s <= 1'b1;
      lk.scl_p <= 1'b1;
      lk.sda_m <= 1'b1;
      lk.sda_s <= 1'b1;
      lk.sda_p <= 1'b1;
      lk.st <= ipma_pkg::S_IDLE;
      for (int i = 0; i < 256; i++) begin
        lk.mem[i] <= ipma_pkg::MEM_RST;
      end
      lk.mem[ipma_pkg::IOCTL0_ADDR] <= ipma_pkg::IOCTL0_RST;
      lk.mem[ipma_pkg::IOCTL1_ADDR] <= ipma_pkg::IOCTL1_RST;
    end else begin
      lk <= next_lk;
    end
  end

  // Program timer on the system clock
  always_comb begin
    next_sy = sy;
    next_sy.tgl_m = lk.commit_tgl;
    next_sy.tgl_s = sy.tgl_m;
    next_sy.tgl_p = sy.tgl_s;
    if (sy.tgl_s != sy.tgl_p) begin
      next_sy.busy = 1'b1;
      next_sy.cnt = CW'(NV_CYC - 1);
    end else if (sy.busy) begin
      if (sy.cnt == '0) begin
        next_sy.busy = 1'b0;
      end else begin
        next_sy.cnt = sy.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  logic dec_saddr, dec_maddr;
  assign dec_saddr = lk.st == ipma_pkg::S_RX && lk.kind == ipma_pkg::K_SADDR && lk.bitcnt == 4'h8
    && ev_fall && !ev_start && !ev_stop;
  assign dec_maddr = lk.st == ipma_pkg::S_RX && lk.kind == ipma_pkg::K_MADDR && lk.bitcnt == 4'h8
    && ev_fall && !ev_start && !ev_stop;

  sequence s_master_nack;
    lk.st == ipma_pkg::S_RACK && ev_rise && lk.sda_s && !ev_start && !ev_stop;
  endsequence
  sequence s_rack_fall;
    lk.st == ipma_pkg::S_RACK && lk.nack && ev_fall && !ev_start && !ev_stop;
  endsequence

  a_foreign_addr_idle: assert property (@(posedge link_clk) disable iff (!rstn)
    dec_saddr && !match |=> lk.st == ipma_pkg::S_IDLE && !lk.sda_oe)
    else $error("foreign address not ignored");
  a_own_addr_ack: assert property (@(posedge link_clk) disable iff (!rstn)
    dec_saddr && lk.shreg[7:1] == {ipma_pkg::SLAVE_ADDR_HI, lk.strap_s} && !lk.pend
    |=> lk.st == ipma_pkg::S_ACK && lk.sda_oe)
    else $error("own address not acknowledged");
  a_busy_no_ack: assert property (@(posedge link_clk) disable iff (!rstn)
    dec_saddr && lk.pend |=> lk.st == ipma_pkg::S_IDLE)
    else $error("address acknowledged while programming");
  a_pointer_load: assert property (@(posedge link_clk) disable iff (!rstn)
    dec_maddr |=> lk.addr == $past(lk.shreg) && lk.sda_oe)
    else $error("memory address not loaded");
  a_row_wrap_inc: assert property (@(posedge link_clk) disable iff (!rstn)
    push_valid && push_ready
    |=> lk.addr[7:3] == $past(lk.addr[7:3]) && lk.addr[2:0] == $past(lk.addr[2:0]) + 3'h1)
    else $error("write counter left its row");
  a_read_from_counter: assert property (@(posedge link_clk) disable iff (!rstn)
    load_now && !ev_start && !ev_stop
    |=> lk.shreg == $past(rd_byte) && lk.addr == $past(lk.addr) + 8'h01 && lk.sda_oe == !lk.shreg[7])
    else $error("read byte not from counter");
  a_nack_taken: assert property (@(posedge link_clk) disable iff (!rstn)
    s_master_nack |=> lk.nack)
    else $error("master nack not taken");
  a_nack_ends_read: assert property (@(posedge link_clk) disable iff (!rstn)
    s_rack_fall |=> lk.st == ipma_pkg::S_IDLE && !lk.sda_oe)
    else $error("read continued after nack");
  a_start_no_commit: assert property (@(posedge link_clk) disable iff (!rstn)
    ev_start && !ev_stop |=> $stable(lk.commit_tgl))
    else $error("programming started without stop");
  a_stop_commit: assert property (@(posedge link_clk) disable iff (!rstn)
    ev_stop && lk.page_dirty |=> lk.commit_tgl != $past(lk.commit_tgl) && lk.pend)
    else $error("stop after data did not program");
  a_shadow_skip: assert property (@(posedge link_clk) disable iff (!rstn)
    drain_valid && drain_ready && shadow_only && daddr >= ipma_pkg::SHADOW_FIRST
    && daddr <= ipma_pkg::SHADOW_LAST && !ev_stop |=> lk.page_dirty == $past(lk.page_dirty))
    else $error("shadow-only write marked page for programming");
  a_busy_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(sy.busy) |-> sy.cnt == CW'(NV_CYC - 1) ##1 sy.busy[*8])
    else $error("program time cut short");
endmodule
`default_nettype wire

// [test/ipma_master.sv]
// Behavioural two-wire bus master facing the slave
`timescale 1ns/100ps
`default_nettype none
module ipma_master #(
  parameter int HALF = 32
) (
  input wire logic sys_clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge sys_clk);
  endtask
  // Release clock, wait out any stretch, then hold the high phase
  task automatic rise();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge sys_clk);
    while (scl_w !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 4000) tb_i2c_paged_memory_access.hang_stop();
    half();
  endtask
  // One bit; data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    repeat (8) @(posedge sys_clk);
    sda_low <= ~b;
    half();
    rise();
    r = sda_w;
    scl_low <= 1'b1;
  endtask
  task automatic start();
    repeat (8) @(posedge sys_clk);
    sda_low <= 1'b0;
    half();
    rise();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
  endtask
  task automatic stop();
    repeat (8) @(posedge sys_clk);
    sda_low <= 1'b1;
    half();
    rise();
    sda_low <= 1'b0;
    half();
  endtask
  // Byte out MSB first, ninth bit read back from the slave
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, nak);
  endtask
  // Byte in MSB first, then master ack or nack
  task automatic get_byte(input logic nak_in, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nak_in, r);
  endtask
endmodule
`default_nettype wire

// [test/tb_i2c_paged_memory_access.sv]
// Self-checking bench for the paged two-wire memory slave
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_paged_memory_access;
  logic sys_clk, rstn, link_clk;
  logic scl_out, scl_oe, sda_out, sda_oe, nv_busy;
  logic scl_low, sda_low;
  logic [2:0] strap;
  logic [7:0] wa;
  wire logic scl_w;
  wire logic sda_w;
  int err_count, check_count;
  // Open-drain wires with pull-ups
  assign scl_w = ~(scl_low | (scl_oe & ~scl_out));
  assign sda_w = ~(sda_low | (sda_oe & ~sda_out));
  assign wa = {ipma_pkg::SLAVE_ADDR_HI, strap, 1'b0};
  ipma_top #(.NV_PROGRAM_TIME_US(10)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .nv_busy(nv_busy)
  );
  ipma_master m (
    .sys_clk(sys_clk), .scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low)
  );
  always #4 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'b0;
    #3;
    forever #24 link_clk = ~link_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang_stop();
    err_count++;
    $display("wrong value at %0t ns: bus wait expired", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_nak);
    logic nak;
    m.put_byte(b, nak);
    chk({7'h00, nak}, {7'h00, exp_nak}, "ninth bit");
  endtask
  // Waits a bounded time for programming busy, then compares it
  task automatic see_busy(input logic exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (nv_busy !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h00, nv_busy}, {7'h00, exp}, "program busy");
  endtask
  // Acknowledge polling until the address is taken
  task automatic poll();
    logic nak;
    int n;
    n = 0;
    nak = 1'b1;
    while (nak === 1'b1 && n < 10) begin
      m.start();
      m.put_byte(wa, nak);
      m.stop();
      n++;
    end
    if (nak !== 1'b0) hang_stop();
    chk({7'h00, nv_busy}, 8'h00, "busy after poll");
  endtask
  task automatic wr_at(input logic [7:0] ptr, input logic [7:0] d[$]);
    m.start();
    send(wa, 1'b0);
    send(ptr, 1'b0);
    foreach (d[i]) send(d[i], 1'b0);
    m.stop();
  endtask
  // Read after a start already issued; last byte gets a nack
  task automatic rd_cur(input logic [7:0] exp[$]);
    logic [7:0] b;
    send(wa | 8'h01, 1'b0);
    foreach (exp[i]) begin
      m.get_byte(i == exp.size() - 1, b);
      chk(b, exp[i], "read data");
    end
    m.stop();
  endtask
  task automatic rd_at(input logic [7:0] ptr, input logic [7:0] exp[$]);
    m.start();
    send(wa, 1'b0);
    send(ptr, 1'b0);
    m.start();
    rd_cur(exp);
  endtask
  task automatic sc_foreign();
    m.start();
    send({ipma_pkg::SLAVE_ADDR_HI, 3'h4, 1'b0}, 1'b1);
    send(wa, 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    see_busy(1'b0);
    @(posedge sys_clk);
    strap <= 3'h4;
    repeat (20) @(posedge sys_clk);
    m.start();
    send(wa, 1'b0);
    m.stop();
    see_busy(1'b0);
    strap <= 3'h5;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic sc_page();
    wr_at(8'h08, '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87});
    see_busy(1'b1);
    m.start();
    send(wa, 1'b1);
    m.stop();
    poll();
    wr_at(8'h0E, '{8'h11, 8'h22, 8'h33});
    see_busy(1'b1);
    poll();
    rd_at(8'h08, '{8'h33, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h11, 8'h22});
  endtask
  task automatic sc_dummy();
    m.start();
    send(wa, 1'b0);
    send(8'h0E, 1'b0);
    m.start();
    rd_cur('{8'h11});
    see_busy(1'b0);
    m.start();
    rd_cur('{8'h22});
  endtask
  task automatic sc_shadow();
    wr_at(ipma_pkg::CFG_ADDR, '{8'h01});
    see_busy(1'b1);
    poll();
    wr_at(8'hF5, '{8'h5A});
    see_busy(1'b0);
    rd_at(ipma_pkg::IOCTL0_ADDR, '{ipma_pkg::IOCTL0_RST, ipma_pkg::IOCTL1_RST, 8'h01, 8'h5A});
  endtask
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    strap = 3'h5;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (40) @(posedge sys_clk);
    sc_foreign();
    sc_page();
    sc_dummy();
    sc_shadow();
    tally_and_finish();
  end
endmodule
`default_nettype wire
